// ==== src/uart_frame_check_addr_match.sv ====
// serial port receive enhancement: framing check and address recognition
// assumes an AXI4-Lite master on the system clock and an async serial line
// Operation
// - three asynchronous modes 1, 2, 3 besides a synchronous mode
// - transmit and receive paths work independently, each at its own rate; only the receive path is built here
// - framing check works in all async modes only while select bit set
// - an invalid stop bit sets the framing error flag
// - framing error stays until software clear or reset, good frames keep it
// - with framing check, receive done rises at the stop bit
// - address recognition active while multiprocessor enable is set
// - with recognition, receive done only for frames addressed to this node
// - mode 1: stop bit is ninth bit; needs address match and valid stop
// - in mode 0 multiprocessor enable has no effect
// - given address is own address with mask-zero bits as don't care
// - an all-ones mask requires an exact eight-bit match
// - broadcast is address OR mask, zero positions don't care
// - accept on given or broadcast match
// - control bit 7 is framing error or upper mode bit per select bit
// - modes 2 and 3 store the received ninth bit
module uart_frame_check_addr_match
	import uart_fc_pkg::*;
(
	input  wire logic        i_clock,    // system clock, 50 MHz
	input  wire logic        i_arst_n,   // async reset, active low
	input  wire logic [7:0]  i_awaddr,   // write address
	input  wire logic        i_awvalid,  // write address valid
	output logic             o_awready,  // write address ready
	input  wire logic [31:0] i_wdata,    // write data
	input  wire logic [3:0]  i_wstrb,    // write byte strobes
	input  wire logic        i_wvalid,   // write data valid
	output logic             o_wready,   // write data ready
	output logic [1:0]       o_bresp,    // write response
	output logic             o_bvalid,   // write response valid
	input  wire logic        i_bready,   // write response ready
	input  wire logic [7:0]  i_araddr,   // read address
	input  wire logic        i_arvalid,  // read address valid
	output logic             o_arready,  // read address ready
	output logic [31:0]      o_rdata,    // read data
	output logic [1:0]       o_rresp,    // read response
	output logic             o_rvalid,   // read data valid
	input  wire logic        i_rready,   // read data ready
	input  wire logic        i_rx_line,  // serial input pin
	output logic             o_irq       // interrupt, active high level
);

	// --------------------------------------------------------------
	// state
	// --------------------------------------------------------------
	logic [7:0]  ctrl_reg;        // bit 7 holds mode_select_hi
	logic        frame_err_reg;   // framing_error_flag
	logic [7:0]  pwr_reg;
	logic [7:0]  addr_reg;
	logic [7:0]  mask_reg;
	logic [7:0]  data_reg;
	logic [1:0]  istat_reg;
	logic [1:0]  imask_reg;
	logic [15:0] div_reg;
	logic [15:0] divcnt_reg;
	logic        tick_reg;
	logic [1:0]  sync_reg;

	// bus holding registers
	logic        aw_held_reg;
	logic [7:0]  aw_addr_reg;
	logic        w_held_reg;
	logic [31:0] w_data_reg;
	logic [3:0]  w_strb_reg;
	logic        bvalid_reg;
	logic [1:0]  bresp_reg;
	logic        rvalid_reg;
	logic [31:0] rdata_reg;
	logic [1:0]  rresp_reg;
	rx_result_t  rx_res;

	// --------------------------------------------------------------
	// line synchroniser and bit-rate tick
	// --------------------------------------------------------------
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			sync_reg <= 2'b11;
		end else begin
			sync_reg <= {sync_reg[0], i_rx_line};
		end
	end

	// >= wraps at once on a smaller divider
	wire logic div_end = (divcnt_reg >= div_reg);

	// 16x tick divider
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			divcnt_reg <= 16'h0000;
			tick_reg   <= 1'b0;
		end else begin
			tick_reg   <= div_end;
			divcnt_reg <= div_end ? 16'h0000 : divcnt_reg + 16'h0001;
		end
	end

	// --------------------------------------------------------------
	// control decode
	// --------------------------------------------------------------
	wire logic      fc_sel   = pwr_reg[PC_FCS];
	wire ser_mode_t mode     = ser_mode_t'({ctrl_reg[SC_BIT7], ctrl_reg[SC_MODE_LO]});
	wire logic      async_md = (mode != MODE_SHIFT);
	// one-cycle event pulses
	wire logic      fe_event = rx_res.done && fc_sel && async_md && !rx_res.stop_ok;
	wire logic      rd_event = rx_res.done && rx_res.accept;

	// receiver sees only the synced line
	uart_rx_frame u_rx (
		.i_clock  (i_clock),
		.i_arst_n (i_arst_n),
		.i_tick   (tick_reg),
		.i_line   (sync_reg[1]),
		.i_enable (ctrl_reg[SC_RX_EN]),
		.i_mode   (mode),
		.i_mpe    (ctrl_reg[SC_MPE]),
		.i_addr   (addr_reg),
		.i_mask   (mask_reg),
		.o_result (rx_res)
	);

	// --------------------------------------------------------------
	// write channel
	// --------------------------------------------------------------
	// a lone half is parked for its partner
	wire logic        aw_ok   = aw_held_reg || i_awvalid;
	wire logic        w_ok    = w_held_reg || i_wvalid;
	wire logic        do_wr   = aw_ok && w_ok && !bvalid_reg;
	wire logic [7:0]  wr_addr = aw_held_reg ? aw_addr_reg : i_awaddr;
	wire logic [31:0] wr_data = w_held_reg ? w_data_reg : i_wdata;
	wire logic [3:0]  wr_strb = w_held_reg ? w_strb_reg : i_wstrb;
	wire logic        wr_b0   = do_wr && wr_strb[0];
	wire logic [7:0]  wb      = wr_data[7:0];
	wire logic        wr_ctrl = wr_b0 && (wr_addr == SER_CTRL_OFS);
	wire logic        wr_pwr  = wr_b0 && (wr_addr == PWR_CTRL_OFS);
	wire logic        wr_stat = wr_b0 && (wr_addr == IRQ_STAT_OFS);
	// unmapped writes: error, no effect
	wire logic        wr_map  = (wr_addr == SER_CTRL_OFS) || (wr_addr == PWR_CTRL_OFS)
	                          || (wr_addr == NODE_ADDR_OFS) || (wr_addr == NODE_MASK_OFS)
	                          || (wr_addr == RX_DATA_OFS) || (wr_addr == IRQ_STAT_OFS)
	                          || (wr_addr == IRQ_MASK_OFS) || (wr_addr == BAUD_DIV_OFS);

	// parked half or pending answer refuses
	assign o_awready = !aw_held_reg && !bvalid_reg;
	assign o_wready  = !w_held_reg && !bvalid_reg;
	assign o_bvalid  = bvalid_reg;
	assign o_bresp   = bresp_reg;

	// hold whichever half arrived first, respond once both are in
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			aw_held_reg <= 1'b0;
			aw_addr_reg <= 8'h00;
			w_held_reg  <= 1'b0;
			w_data_reg  <= 32'h0000_0000;
			w_strb_reg  <= 4'h0;
			bvalid_reg  <= 1'b0;
			bresp_reg   <= AXI_OKAY;
		end else begin
			if (do_wr) begin
				aw_held_reg <= 1'b0;
				w_held_reg  <= 1'b0;
				bvalid_reg  <= 1'b1;
				bresp_reg   <= wr_map ? AXI_OKAY : AXI_SLVERR;
			end else begin
				if (i_awvalid && o_awready) begin
					aw_held_reg <= 1'b1;
					aw_addr_reg <= i_awaddr;
				end
				if (i_wvalid && o_wready) begin
					w_held_reg <= 1'b1;
					w_data_reg <= i_wdata;
					w_strb_reg <= i_wstrb;
				end
				if (bvalid_reg && i_bready) begin
					bvalid_reg <= 1'b0;
				end
			end
		end
	end

	// --------------------------------------------------------------
	// registers software writes
	// --------------------------------------------------------------
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			pwr_reg   <= PWR_CTRL_RST;
			addr_reg  <= ADDR_RST;
			mask_reg  <= ADDR_RST;
			imask_reg <= 2'b00;
			div_reg   <= BAUD_DIV_RST;
		end else begin
			if (wr_pwr) begin
				pwr_reg <= wb;
			end
			if (wr_b0 && (wr_addr == NODE_ADDR_OFS)) begin
				addr_reg <= wb;
			end
			if (wr_b0 && (wr_addr == NODE_MASK_OFS)) begin
				mask_reg <= wb;
			end
			if (wr_b0 && (wr_addr == IRQ_MASK_OFS)) begin
				imask_reg <= wb[1:0];
			end
			// divider bytes by their own strobes
			if (do_wr && (wr_addr == BAUD_DIV_OFS)) begin
				if (wr_strb[0]) div_reg[7:0]  <= wb;
				if (wr_strb[1]) div_reg[15:8] <= wr_data[15:8];
			end
		end
	end

	// bit 7 write goes to error flag or mode bit by select
	wire logic ctrl7_mode = wr_ctrl && !fc_sel;
	wire logic fe_clear   = wr_ctrl && fc_sel && !wb[SC_BIT7];

	// control register with hardware-set flags, set wins over clear
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			ctrl_reg      <= SER_CTRL_RST;
			frame_err_reg <= 1'b0;
			data_reg      <= 8'h00;
		end else begin
			if (wr_ctrl) begin
				ctrl_reg[6:0] <= wb[6:0];
			end
			if (ctrl7_mode) begin
				ctrl_reg[SC_BIT7] <= wb[SC_BIT7];
			end
			if (fe_event) begin
				frame_err_reg <= 1'b1;
			end else if (fe_clear) begin
				frame_err_reg <= 1'b0;
			end
			if (rd_event) begin
				ctrl_reg[SC_RX_DONE] <= 1'b1;
				data_reg             <= rx_res.data;
				if (mode == MODE_UART9F || mode == MODE_UART9V) begin
					ctrl_reg[SC_NINTH] <= rx_res.ninth;
				end
			end
		end
	end

	// sticky interrupt status, write one to clear, set wins
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			istat_reg <= 2'b00;
		end else begin
			istat_reg <= (istat_reg & ~(wr_stat ? wb[1:0] : 2'b00))
			           | {fe_event, rd_event};
		end
	end

	// level while an enabled event waits
	assign o_irq = |(istat_reg & imask_reg);

	// --------------------------------------------------------------
	// read channel
	// --------------------------------------------------------------
	// bit 7: error flag or mode bit
	wire logic [7:0] ctrl_view = {fc_sel ? frame_err_reg : ctrl_reg[SC_BIT7],
	                              ctrl_reg[6:0]};
	wire logic       rd_map    = (i_araddr == SER_CTRL_OFS) || (i_araddr == PWR_CTRL_OFS)
	                          || (i_araddr == NODE_ADDR_OFS) || (i_araddr == NODE_MASK_OFS)
	                          || (i_araddr == RX_DATA_OFS) || (i_araddr == IRQ_STAT_OFS)
	                          || (i_araddr == IRQ_MASK_OFS) || (i_araddr == BAUD_DIV_OFS);
	// upper bits read as zero
	wire logic [31:0] rd_mux =
		(i_araddr == SER_CTRL_OFS)  ? {24'h000000, ctrl_view} :
		(i_araddr == PWR_CTRL_OFS)  ? {24'h000000, pwr_reg} :
		(i_araddr == NODE_ADDR_OFS) ? {24'h000000, addr_reg} :
		(i_araddr == NODE_MASK_OFS) ? {24'h000000, mask_reg} :
		(i_araddr == RX_DATA_OFS)   ? {24'h000000, data_reg} :
		(i_araddr == IRQ_STAT_OFS)  ? {30'h00000000, istat_reg} :
		(i_araddr == IRQ_MASK_OFS)  ? {30'h00000000, imask_reg} :
		(i_araddr == BAUD_DIV_OFS)  ? {16'h0000, div_reg} : 32'h0000_0000;

	// one read in flight at a time
	assign o_arready = !rvalid_reg;
	assign o_rvalid  = rvalid_reg;
	assign o_rdata   = rdata_reg;
	assign o_rresp   = rresp_reg;

	// read answer one cycle after the address is taken
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			rvalid_reg <= 1'b0;
			rdata_reg  <= 32'h0000_0000;
			rresp_reg  <= AXI_OKAY;
		end else if (i_arvalid && !rvalid_reg) begin
			rvalid_reg <= 1'b1;
			rdata_reg  <= rd_mux;
			rresp_reg  <= rd_map ? AXI_OKAY : AXI_SLVERR;
		end else if (rvalid_reg && i_rready) begin
			rvalid_reg <= 1'b0;
		end
	end

endmodule

// ==== include/uart_fc_pkg.sv ====
// package for the serial receive enhancement block: register map, fields, resets
// assumes a 50 MHz single clock and an AXI4-Lite register port
package uart_fc_pkg;

	// ----------------------------------------------------------------
	// register byte addresses
	// ----------------------------------------------------------------
	localparam logic [7:0] SER_CTRL_OFS  = 8'h00;   // serial_control_reg
	localparam logic [7:0] PWR_CTRL_OFS  = 8'h04;   // power_control_reg
	localparam logic [7:0] NODE_ADDR_OFS = 8'h08;   // own_node_address
	localparam logic [7:0] NODE_MASK_OFS = 8'h0C;   // node_address_mask
	localparam logic [7:0] RX_DATA_OFS   = 8'h10;   // received byte, read only
	localparam logic [7:0] IRQ_STAT_OFS  = 8'h14;   // sticky events, write one to clear
	localparam logic [7:0] IRQ_MASK_OFS  = 8'h18;   // interrupt enables
	localparam logic [7:0] BAUD_DIV_OFS  = 8'h1C;   // bit-rate divider

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int SC_BIT7     = 7;   // framing_error_flag or mode_select_hi
	localparam int SC_MODE_LO  = 6;
	localparam int SC_MPE      = 5;   // multiproc_enable
	localparam int SC_RX_EN    = 4;
	localparam int SC_TX_NINTH = 3;
	localparam int SC_NINTH    = 2;   // rx_ninth_bit
	localparam int SC_TX_DONE  = 1;
	localparam int SC_RX_DONE  = 0;   // rx_done_flag
	localparam int PC_DOUBLE   = 7;
	localparam int PC_FCS      = 6;   // framing_check_select
	localparam int IS_RX_DONE  = 0;
	localparam int IS_FRAME    = 1;

	// ----------------------------------------------------------------
	// reset values and timing
	// ----------------------------------------------------------------
	localparam logic [7:0]  SER_CTRL_RST = 8'h00;
	localparam logic [7:0]  PWR_CTRL_RST = 8'h00;
	localparam logic [7:0]  ADDR_RST     = 8'h00;
	localparam logic [15:0] BAUD_DIV_RST = 16'h01B2;  // 16x oversample tick, ~7200 baud
	localparam logic [3:0]  OVS_LAST     = 4'hF;      // 16 ticks per bit
	localparam logic [3:0]  OVS_MID      = 4'h7;      // sample point
	localparam logic [1:0]  AXI_OKAY     = 2'b00;
	localparam logic [1:0]  AXI_SLVERR   = 2'b10;

	typedef enum logic [1:0] {
		MODE_SHIFT,
		MODE_UART8,
		MODE_UART9F,
		MODE_UART9V
	} ser_mode_t;

	// frame result handed from the receiver to the register file
	typedef struct packed {
		logic       done;      // one-cycle pulse, frame finished
		logic [7:0] data;
		logic       ninth;     // ninth bit or stop bit in mode 1
		logic       stop_ok;
		logic       accept;    // rx_done_flag may be raised
	} rx_result_t;

endpackage

// ==== src/uart_rx_frame.sv ====
// asynchronous receiver with stop-bit check and address filter
// assumes a synchronised line input and a 16x tick enable from the parent
module uart_rx_frame
	import uart_fc_pkg::*;
(
	input  wire logic       i_clock,     // system clock
	input  wire logic       i_arst_n,    // async reset, active low
	input  wire logic       i_tick,      // 16x oversample enable
	input  wire logic       i_line,      // synchronised serial input
	input  wire logic       i_enable,    // reception enabled
	input  wire ser_mode_t  i_mode,      // operating mode
	input  wire logic       i_mpe,       // multiproc_enable
	input  wire logic [7:0] i_addr,      // own_node_address
	input  wire logic [7:0] i_mask,      // node_address_mask
	output rx_result_t      o_result     // frame result
);

	typedef enum logic [1:0] {ST_IDLE, ST_START, ST_DATA, ST_STOP} rx_state_t;

	rx_state_t  state_reg;
	logic [3:0] ovs_reg;
	logic [3:0] bit_reg;
	logic [8:0] shift_reg;
	rx_result_t result_reg;
	logic       line_prev_reg;  // line one cycle ago

	// --------------------------------------------------------------
	// address compare
	// --------------------------------------------------------------
	wire logic       nine_bit   = (i_mode == MODE_UART9F) || (i_mode == MODE_UART9V);
	wire logic [3:0] last_bit   = nine_bit ? 4'h8 : 4'h7;
	wire logic       filter_on  = i_mpe && (i_mode != MODE_SHIFT);
	wire logic [7:0] rx_byte    = shift_reg[7:0];
	wire logic [7:0] bcast      = i_addr | i_mask;
	wire logic       given_hit  = ((rx_byte ^ i_addr) & i_mask) == 8'h00;
	wire logic       bcast_hit  = (rx_byte & bcast) == bcast;
	wire logic       addr_hit   = given_hit || bcast_hit;
	wire logic       sample     = i_tick && (ovs_reg == OVS_MID);
	wire logic       stop_valid = i_line;
	// mode 1 uses the stop bit as ninth bit; modes 2/3 use the received one
	wire logic       addr_frame = nine_bit ? shift_reg[8] : stop_valid;
	wire logic       accept     = !filter_on || (addr_frame && addr_hit
	                              && (nine_bit || stop_valid));

	// --------------------------------------------------------------
	// receive sequencer: idle, start, data and stop states
	// --------------------------------------------------------------
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			state_reg  <= ST_IDLE;
			ovs_reg    <= 4'h0;
			bit_reg    <= 4'h0;
			shift_reg  <= 9'h000;
			result_reg <= '0;
			line_prev_reg <= 1'b1;
		end else begin
			line_prev_reg <= i_line;
			result_reg.done <= 1'b0;
			if (i_tick) begin
				ovs_reg <= ovs_reg + 4'h1;
			end
			unique case (state_reg)
				ST_IDLE: begin
					ovs_reg <= 4'h0;
					// falling edge only: a low stop bit cannot restart
					if (i_enable && line_prev_reg && !i_line && (i_mode != MODE_SHIFT)) begin
						state_reg <= ST_START;
					end
				end
				ST_START: begin
					if (sample) begin
						state_reg <= i_line ? ST_IDLE : ST_DATA;
						bit_reg   <= 4'h0;
					end
				end
				ST_DATA: begin
					if (sample) begin
						shift_reg <= nine_bit ? {i_line, shift_reg[8:1]}
						                      : {1'b0, i_line, shift_reg[7:1]};
						bit_reg   <= bit_reg + 4'h1;
						if (bit_reg == last_bit) begin
							state_reg <= ST_STOP;
						end
					end
				end
				ST_STOP: begin
					// result posted at the stop bit sample point
					if (sample) begin
						state_reg          <= ST_IDLE;
						result_reg.done    <= 1'b1;
						result_reg.data    <= rx_byte;
						result_reg.ninth   <= nine_bit ? shift_reg[8] : stop_valid;
						result_reg.stop_ok <= stop_valid;
						result_reg.accept  <= accept;
					end
				end
			endcase
		end
	end

	assign o_result = result_reg;

endmodule

// ==== verif/uart_fc_props.sv ====
// checker: register-port handshake and response properties
// assumes a bind onto uart_frame_check_addr_match, one clock domain
module uart_fc_props
	import uart_fc_pkg::*;
(
	input wire logic        i_clock,   // system clock
	input wire logic        i_arst_n,  // async reset, active low
	input wire logic        i_awvalid, // write address valid
	input wire logic        o_awready, // write address ready
	input wire logic        i_wvalid,  // write data valid
	input wire logic        o_wready,  // write data ready
	input wire logic [1:0]  o_bresp,   // write response
	input wire logic        o_bvalid,  // write response valid
	input wire logic        i_bready,  // write response ready
	input wire logic        i_arvalid, // read address valid
	input wire logic        o_arready, // read address ready
	input wire logic [31:0] o_rdata,   // read data
	input wire logic [1:0]  o_rresp,   // read response
	input wire logic        o_rvalid,  // read data valid
	input wire logic        i_rready   // read data ready
);
	timeunit 1ns;
	timeprecision 1ns;
	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (!i_arst_n);

	// both halves of a write taken at one edge
	sequence wr_taken_s;
		i_awvalid && o_awready && i_wvalid && o_wready;
	endsequence
	sequence rd_taken_s;
		i_arvalid && o_arready;
	endsequence

	// answers come one cycle after the request is taken
	write_answer_a: assert property (wr_taken_s |=> o_bvalid)
		else $error("write response missing");
	read_answer_a: assert property (rd_taken_s |-> ##1 o_rvalid)
		else $error("read response missing");
	// responses stand until accepted, then drop
	bresp_hold_a: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
		else $error("write response not held");
	rdata_hold_a: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata)
		&& $stable(o_rresp)) else $error("read response not held");
	b_release_a: assert property (o_bvalid && i_bready |=> !o_bvalid)
		else $error("write response not released");
	r_release_a: assert property (o_rvalid && i_rready |=> !o_rvalid)
		else $error("read response not released");
	// refusals while a response is pending, zero data on error reads
	write_refuse_a: assert property (o_bvalid |-> !o_awready && !o_wready)
		else $error("write taken while response pending");
	read_refuse_a: assert property (o_rvalid |-> !o_arready)
		else $error("read taken while response pending");
	slverr_zero_a: assert property (o_rvalid && o_rresp == AXI_SLVERR |-> o_rdata == 32'h00000000)
		else $error("error read returned data");
endmodule

bind uart_frame_check_addr_match uart_fc_props uart_fc_props_i (.i_clock(i_clock),
	.i_arst_n(i_arst_n), .i_awvalid(i_awvalid), .o_awready(o_awready), .i_wvalid(i_wvalid),
	.o_wready(o_wready), .o_bresp(o_bresp), .o_bvalid(o_bvalid), .i_bready(i_bready),
	.i_arvalid(i_arvalid), .o_arready(o_arready), .o_rdata(o_rdata), .o_rresp(o_rresp),
	.o_rvalid(o_rvalid), .i_rready(i_rready));

// ==== verif/line_peer.sv ====
// remote serial node: sends frames on the line, lsb first
// assumes the bench clock and a fixed bit length in clocks
module line_peer #(
	parameter int BIT_CLKS = 64
) (
	input  wire logic i_clock, // bench clock
	output logic      o_line   // serial line, idle high
);
	timeunit 1ns;
	timeprecision 1ns;
	initial o_line = 1'b1;

	// start, eight data bits, optional ninth, stop, then idle
	task automatic send(input logic [7:0] d, input logic has9, input logic b9,
		input logic stp);
		logic [10:0] bits;
		int          n;
		bits = {stp, b9, d, 1'b0};
		n = has9 ? 11 : 10;
		if (!has9) bits[9] = stp;
		for (int i = 0; i < n; i++) begin
			@(posedge i_clock);
			o_line <= bits[i];
			repeat (BIT_CLKS - 1) @(posedge i_clock);
		end
		@(posedge i_clock);
		o_line <= 1'b1;
		repeat (BIT_CLKS) @(posedge i_clock);
	endtask
endmodule

// ==== verif/tb.sv ====
// testbench: register access, framing check and address filter
// assumes divider 3 gives 64 clocks per serial bit
module tb
	import uart_fc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct {logic [31:0] val; logic [31:0] msk; logic [1:0] resp; logic [7:0] adr;} exp_t;
	typedef struct packed {logic [7:0] ctrl; logic [7:0] mask; logic [7:0] data;
		logic b9; logic stp; logic hit;} case_t;
	localparam case_t CASES [9] = '{
		'{8'hF0, 8'hFC, 8'h55, 1'b1, 1'b1, 1'b1}, '{8'hF0, 8'hFC, 8'h5A, 1'b1, 1'b1, 1'b0},
		'{8'hF0, 8'hFC, 8'hFE, 1'b1, 1'b1, 1'b1}, '{8'hF0, 8'hFC, 8'h55, 1'b0, 1'b1, 1'b0},
		'{8'hF0, 8'hFF, 8'h57, 1'b1, 1'b1, 1'b0}, '{8'hF0, 8'hFF, 8'h56, 1'b1, 1'b1, 1'b1},
		'{8'h70, 8'hFF, 8'h56, 1'b0, 1'b1, 1'b1}, '{8'h70, 8'hFF, 8'h56, 1'b0, 1'b0, 1'b0},
		'{8'h70, 8'hFF, 8'h57, 1'b0, 1'b1, 1'b0}};
	exp_t        rq[$];
	logic [1:0]  bq[$];
	int          n_mismatch = 0;
	int          n_tests = 0;
	int          cycles = 0;
	logic [31:0] seed = 32'h00017D54;
	logic [31:0] x;
	logic        clock = 1'b0;
	logic        arst_n = 1'b0;
	logic [7:0]  awaddr = 8'h00;
	logic [7:0]  araddr = 8'h00;
	logic [31:0] wdata = 32'h00000000;
	logic [3:0]  wstrb = 4'h0;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic        awready, wready, bvalid, arready, rvalid, irq, line;
	logic [1:0]  bresp, rresp;
	logic [31:0] rdata;

	always #10 clock = ~clock;

	uart_frame_check_addr_match uart_frame_check_addr_match_i (.i_clock(clock),
		.i_arst_n(arst_n), .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready),
		.i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(wready),
		.o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr),
		.i_arvalid(arvalid), .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp),
		.o_rvalid(rvalid), .i_rready(rready), .i_rx_line(line), .o_irq(irq));
	line_peer #(.BIT_CLKS(64)) line_peer_i (.i_clock(clock), .o_line(line));

	// ----------------------------------------------------------------
	// compare, verdict and bus tasks
	// ----------------------------------------------------------------
	task automatic chk_val(input string what, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic chk_resp(input string what, input logic [1:0] e, input logic [1:0] g);
		n_tests++;
		if (g !== e) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	function automatic logic [1:0] resp_of(input logic [7:0] a);
		return (a > BAUD_DIV_OFS) ? AXI_SLVERR : AXI_OKAY;
	endfunction
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic ah, wh, bh;
		@(posedge clock);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= d;
		wstrb <= 4'hF;
		wvalid <= 1'b1;
		bready <= 1'b1;
		bq.push_back(resp_of(a));
		do begin
			@(negedge clock);
			ah = awvalid & awready;
			wh = wvalid & wready;
			bh = bvalid & bready;
			@(posedge clock);
			if (ah) awvalid <= 1'b0;
			if (wh) wvalid <= 1'b0;
		end while (!bh);
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
		logic ah, rh;
		@(posedge clock);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		rq.push_back('{e, m, resp_of(a), a});
		do begin
			@(negedge clock);
			ah = arvalid & arready;
			rh = rvalid & rready;
			@(posedge clock);
			if (ah) arvalid <= 1'b0;
		end while (!rh);
		rready <= 1'b0;
	endtask
	task automatic irq_is(input logic e);
		@(negedge clock);
		chk_val("irq", {31'h0, e}, {31'h0, irq});
	endtask

	// result watcher: oldest note against each accepted response
	always @(negedge clock) begin
		exp_t e;
		if (rvalid && rready) begin
			e = rq.pop_front();
			chk_val($sformatf("rdata %h", e.adr), e.val & e.msk, rdata & e.msk);
			chk_resp("rresp", e.resp, rresp);
		end
		if (bvalid && bready) chk_resp("bresp", bq.pop_front(), bresp);
	end

	// hang guard
	always @(posedge clock) begin
		cycles++;
		if (cycles == 40000) begin
			n_mismatch++;
			give_verdict;
		end
	end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (5) @(posedge clock);
		arst_n <= 1'b1;
		rd(SER_CTRL_OFS, {24'h0, SER_CTRL_RST}, 32'hFFFFFFFF);
		rd(PWR_CTRL_OFS, {24'h0, PWR_CTRL_RST}, 32'hFFFFFFFF);
		rd(NODE_ADDR_OFS, {24'h0, ADDR_RST}, 32'hFFFFFFFF);
		rd(NODE_MASK_OFS, {24'h0, ADDR_RST}, 32'hFFFFFFFF);
		rd(BAUD_DIV_OFS, {16'h0, BAUD_DIV_RST}, 32'hFFFFFFFF);
		rd(8'h20, 32'h00000000, 32'hFFFFFFFF);
		wr(8'h24, 32'h00000005);
		wr(BAUD_DIV_OFS, 32'h00000003);
		$display("test reset done");
		wr(SER_CTRL_OFS, 32'h00000050);
		wr(IRQ_MASK_OFS, 32'h00000001);
		repeat (3) begin
			x = rnd();
			line_peer_i.send(x[7:0], 1'b0, 1'b0, 1'b1);
			rd(RX_DATA_OFS, {24'h0, x[7:0]}, 32'h000000FF);
			rd(SER_CTRL_OFS, 32'h00000001, 32'h00000001);
			irq_is(1'b1);
			wr(IRQ_STAT_OFS, 32'h00000001);
			irq_is(1'b0);
			wr(SER_CTRL_OFS, 32'h00000050);
		end
		wr(IRQ_MASK_OFS, 32'h00000000);
		line_peer_i.send(8'h3C, 1'b0, 1'b0, 1'b1);
		irq_is(1'b0);
		wr(IRQ_MASK_OFS, 32'h00000001);
		irq_is(1'b1);
		wr(IRQ_STAT_OFS, 32'h00000003);
		$display("test mode1 and irq done");
		wr(PWR_CTRL_OFS, 32'h00000040);
		line_peer_i.send(8'h11, 1'b0, 1'b0, 1'b0);
		rd(SER_CTRL_OFS, 32'h00000080, 32'h00000080);
		rd(IRQ_STAT_OFS, 32'h00000002, 32'h00000002);
		line_peer_i.send(8'h22, 1'b0, 1'b0, 1'b1);
		rd(SER_CTRL_OFS, 32'h00000081, 32'h00000081);
		wr(SER_CTRL_OFS, 32'h00000050);
		rd(SER_CTRL_OFS, 32'h00000000, 32'h00000080);
		wr(PWR_CTRL_OFS, 32'h00000000);
		wr(IRQ_STAT_OFS, 32'h00000003);
		line_peer_i.send(8'h33, 1'b0, 1'b0, 1'b0);
		rd(IRQ_STAT_OFS, 32'h00000000, 32'h00000002);
		$display("test framing done");
		wr(NODE_ADDR_OFS, 32'h00000056);
		foreach (CASES[i]) begin
			wr(NODE_MASK_OFS, {24'h0, CASES[i].mask});
			wr(SER_CTRL_OFS, {24'h0, CASES[i].ctrl});
			line_peer_i.send(CASES[i].data, CASES[i].ctrl[7], CASES[i].b9, CASES[i].stp);
			rd(SER_CTRL_OFS, {31'h0, CASES[i].hit}, 32'h00000001);
			if (CASES[i].hit) rd(RX_DATA_OFS, {24'h0, CASES[i].data}, 32'h000000FF);
		end
		wr(SER_CTRL_OFS, 32'h00000030);
		line_peer_i.send(8'h56, 1'b0, 1'b0, 1'b1);
		rd(SER_CTRL_OFS, 32'h00000000, 32'h00000001);
		$display("test address filter done");
		wr(SER_CTRL_OFS, 32'h00000090);
		for (int b = 1; b >= 0; b--) begin
			line_peer_i.send(8'h33, 1'b1, b[0], 1'b1);
			rd(SER_CTRL_OFS, {29'h0, b[0], 2'b00}, 32'h00000004);
		end
		$display("test ninth bit done");
		repeat (4) @(posedge clock);
		give_verdict;
	end
endmodule
